// File: rtl/pio_line_ctrl.sv
/*
 pio_line_ctrl: 32-line parallel i/o control with wishbone registers.
 assumes classic wishbone master, pins and two peripherals outside.
*/
// Local design decisions: the address map and the Wishbone interface to the registers.
// How it works
// - pull-up enable clears, disable sets status
// - pull-up status 1 means disabled
// - pull-up works any function; resets 0
// - ctrl enable/disable set/clear function select
// - unmuxed lines ignore select, read 1
// - function select reset is product constant
// - a/b select writes clear/set choice
// - choice steers outputs only; inputs see pin
// - choice status resets to zero
// - a/b writes act whatever line assignment
// - peripheral lines driven by chosen peripheral
// - output enable/disable set/clear status
// - set/clear output write data status
// - output writes stored while peripheral owns
// - direct data write only masked bits
// - mask enable/disable; mask resets zero
// - multidrive drives only low, releases high
// - multidrive set/clear any assignment, resets zero
// - config writes work with clock stopped
// - pin sampling only while clock enabled
// - no interrupt while clock disabled
// - 32-bit registers, bit n is line n
// - pin status shows held sampled levels
`timescale 1ns/100ps
module pio_line_ctrl
   import pio_pkg::*;
#(
   parameter logic [31:0] MUXED = PIO_MUXED_DEF,
   parameter logic [31:0] FSEL_RESET = PIO_FSEL_RST
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic periph_clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [PIO_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe_n,
   output logic [31:0] pullup_on,
   input wire logic [31:0] periph_a_out,
   input wire logic [31:0] periph_a_oe,
   input wire logic [31:0] periph_b_out,
   input wire logic [31:0] periph_b_oe,
   output logic [31:0] periph_pin_in,
   output logic ctrl_irq
);
   pio_wr_if wr ();
   logic [31:0] function_select_status;
   logic [31:0] periph_choice_status;
   logic [31:0] output_status_reg;
   logic [31:0] output_data_status;
   logic [31:0] out_write_mask_status;
   logic [31:0] multidrive_status_reg;
   logic [31:0] pullup_status_reg;
   logic [31:0] pin_level_status;
   logic [31:0] wmask;
   logic [31:0] d;
   logic [31:0] next_rdata;
   logic [31:0] next_out;
   logic [31:0] next_oe_n;
   logic hit;

   // ------------------------------------------------------------
   // bus slave: one wait state, ack drops after one cycle
   // ------------------------------------------------------------
   assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= hit;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lane
         assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   assign wr.we = hit && wb_we_i;
   assign wr.addr = {wb_adr_i[7:2], 2'b00};
   assign wr.data = wb_dat_i & wmask;
   assign d = wr.data;

   always_comb
   begin
      next_rdata = PIO_RST_ZERO;
      if (wr.addr == PIO_FSEL_ST)
         next_rdata = function_select_status;
      else if (wr.addr == PIO_OE_ST)
         next_rdata = output_status_reg;
      else if (wr.addr == PIO_OUT_ST)
         next_rdata = output_data_status;
      else if (wr.addr == PIO_PIN_ST)
         next_rdata = pin_level_status;
      else if (wr.addr == PIO_MD_ST)
         next_rdata = multidrive_status_reg;
      else if (wr.addr == PIO_PU_ST)
         next_rdata = pullup_status_reg;
      else if (wr.addr == PIO_AB_ST)
         next_rdata = periph_choice_status;
      else if (wr.addr == PIO_OW_ST)
         next_rdata = out_write_mask_status;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         wb_dat_o <= PIO_RST_ZERO;
      else if (hit && !wb_we_i)
         wb_dat_o <= next_rdata;
   end

   // ------------------------------------------------------------
   // configuration registers, clocked on the bus clock
   // ------------------------------------------------------------
   // the bus clock runs regardless of periph_clk_en
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         pullup_status_reg <= PIO_RST_ZERO;
      else if (wr.we && wr.addr == PIO_PU_EN)
         pullup_status_reg <= pullup_status_reg & ~d;
      else if (wr.we && wr.addr == PIO_PU_DIS)
         pullup_status_reg <= pullup_status_reg | d;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         function_select_status <= FSEL_RESET | ~MUXED;
      else if (wr.we && wr.addr == PIO_CTRL_EN)
         function_select_status <= function_select_status | d;
      else if (wr.we && wr.addr == PIO_CTRL_DIS)
         function_select_status <= (function_select_status & ~d)
            | ~MUXED;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         periph_choice_status <= PIO_RST_ZERO;
      else if (wr.we && wr.addr == PIO_A_SEL)
         periph_choice_status <= periph_choice_status & ~d;
      else if (wr.we && wr.addr == PIO_B_SEL)
         periph_choice_status <= periph_choice_status | d;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         output_status_reg <= PIO_RST_ZERO;
      else if (wr.we && wr.addr == PIO_OE_EN)
         output_status_reg <= output_status_reg | d;
      else if (wr.we && wr.addr == PIO_OE_DIS)
         output_status_reg <= output_status_reg & ~d;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         output_data_status <= PIO_RST_ZERO;
      else if (wr.we && wr.addr == PIO_OUT_SET)
         output_data_status <= output_data_status | d;
      else if (wr.we && wr.addr == PIO_OUT_CLR)
         output_data_status <= output_data_status & ~d;
      else if (wr.we && wr.addr == PIO_OUT_ST)
         output_data_status <= (output_data_status
            & ~(out_write_mask_status & wmask))
            | (d & out_write_mask_status);
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         out_write_mask_status <= PIO_RST_ZERO;
      else if (wr.we && wr.addr == PIO_OW_EN)
         out_write_mask_status <= out_write_mask_status | d;
      else if (wr.we && wr.addr == PIO_OW_DIS)
         out_write_mask_status <= out_write_mask_status & ~d;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         multidrive_status_reg <= PIO_RST_ZERO;
      else if (wr.we && wr.addr == PIO_MD_EN)
         multidrive_status_reg <= multidrive_status_reg | d;
      else if (wr.we && wr.addr == PIO_MD_DIS)
         multidrive_status_reg <= multidrive_status_reg & ~d;
   end

   // ------------------------------------------------------------
   // pin input sampling
   // ------------------------------------------------------------
   pio_sync #(
      .WIDTH(PIO_LINES)
   ) u_sync (
      .clock(clock),
      .resetn(resetn),
      .sample_en(periph_clk_en),
      .pin_async(pin_in),
      .pin_level(pin_level_status)
   );

   // ------------------------------------------------------------
   // output multiplexing per line
   // ------------------------------------------------------------
   always_comb
   begin
      next_out = '0;
      next_oe_n = '1;
      for (int i = 0; i < PIO_LINES; i++)
      begin
         logic o;
         logic e;
         o = 1'b0;
         e = 1'b0;
         if (function_select_status[i])
         begin
            o = output_data_status[i];
            e = output_status_reg[i];
         end
         else if (periph_choice_status[i])
         begin
            o = periph_b_out[i];
            e = periph_b_oe[i];
         end
         else
         begin
            o = periph_a_out[i];
            e = periph_a_oe[i];
         end
         if (multidrive_status_reg[i])
         begin
            e = e && !o;
            o = 1'b0;
         end
         next_out[i] = o;
         next_oe_n[i] = !e;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_out <= '0;
         pin_oe_n <= '1;
         pullup_on <= '1;
         periph_pin_in <= '0;
         ctrl_irq <= 1'b0;
      end
      else
      begin
         pin_out <= next_out;
         pin_oe_n <= next_oe_n;
         pullup_on <= ~pullup_status_reg;
         periph_pin_in <= pin_level_status;
         ctrl_irq <= 1'b0;
      end
   end
endmodule

// File: rtl/pio_pkg.sv
/*
 pio_pkg: register offsets, reset values and widths for the parallel
 i/o line controller.
 assumes a 32-bit classic wishbone slave with byte addressing.
*/
package pio_pkg;
   localparam int PIO_LINES = 32;
   localparam int PIO_AW = 8;
   // register byte offsets
   localparam logic [7:0] PIO_CTRL_EN = 8'h00;
   localparam logic [7:0] PIO_CTRL_DIS = 8'h04;
   localparam logic [7:0] PIO_FSEL_ST = 8'h08;
   localparam logic [7:0] PIO_OE_EN = 8'h10;
   localparam logic [7:0] PIO_OE_DIS = 8'h14;
   localparam logic [7:0] PIO_OE_ST = 8'h18;
   localparam logic [7:0] PIO_OUT_SET = 8'h30;
   localparam logic [7:0] PIO_OUT_CLR = 8'h34;
   localparam logic [7:0] PIO_OUT_ST = 8'h38;
   localparam logic [7:0] PIO_PIN_ST = 8'h3C;
   localparam logic [7:0] PIO_MD_EN = 8'h50;
   localparam logic [7:0] PIO_MD_DIS = 8'h54;
   localparam logic [7:0] PIO_MD_ST = 8'h58;
   localparam logic [7:0] PIO_PU_DIS = 8'h60;
   localparam logic [7:0] PIO_PU_EN = 8'h64;
   localparam logic [7:0] PIO_PU_ST = 8'h68;
   localparam logic [7:0] PIO_A_SEL = 8'h70;
   localparam logic [7:0] PIO_B_SEL = 8'h74;
   localparam logic [7:0] PIO_AB_ST = 8'h78;
   localparam logic [7:0] PIO_OW_EN = 8'hA0;
   localparam logic [7:0] PIO_OW_DIS = 8'hA4;
   localparam logic [7:0] PIO_OW_ST = 8'hA8;
   // reset values
   localparam logic [31:0] PIO_RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] PIO_FSEL_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] PIO_MUXED_DEF = 32'hFFFF_FFFF;
endpackage

// File: rtl/pio_wr_if.sv
/*
 pio_wr_if: decoded register write strobes from bus slave to core.
 assumes one clock domain.
*/
`timescale 1ns/100ps
interface pio_wr_if;
   logic we;
   logic [7:0] addr;
   logic [31:0] data;
   modport src
   (
      output we,
      output addr,
      output data
   );
   modport dst
   (
      input we,
      input addr,
      input data
   );
endinterface

// File: rtl/pio_sync.sv
/*
 pio_sync: two flip-flop synchroniser per pin, gated by the controller
 clock enable so the last sampled level is held while stopped.
 assumes async pins.
*/
`timescale 1ns/100ps
module pio_sync
   import pio_pkg::*;
#(
   parameter int WIDTH = PIO_LINES
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic sample_en,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_level
);
   logic [WIDTH-1:0] meta;
   // -------------------------------------------------
   // two stage crossing, held when clock disabled
   // -------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         meta <= '0;
         pin_level <= '0;
      end
      else if (sample_en)
      begin
         meta <= pin_async;
         pin_level <= meta;
      end
   end
endmodule

// File: tb/pio_line_ctrl_checker.sv
/*
 pio_line_ctrl_checker: port timing of bus, pull-ups and pin sampling.
 assumes it is bound to pio_line_ctrl.
*/
`timescale 1ns/100ps
module pio_line_ctrl_checker
   import pio_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic periph_clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [PIO_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pullup_on,
   input wire logic [31:0] periph_pin_in,
   input wire logic ctrl_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic wr;
   logic rd;
   assign wr = wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
   assign rd = wb_ack_o && !wb_we_i;
   // ----
   // assertions
   // ----
   ack_answer_a:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   irq_off_a:
      assert property (!periph_clk_en |-> !ctrl_irq) else $error("irq");
   pin_hold_a:
      assert property (!periph_clk_en [*3] |=> $stable(periph_pin_in))
      else $error("pin level moved while stopped");
   periph_in_a:
      assert property ((periph_clk_en && $stable(pin_in)) [*5]
         |-> periph_pin_in == pin_in) else $error("periph input");
   pu_dis_a:
      assert property (wr && wb_adr_i == PIO_PU_DIS
         |=> (pullup_on & $past(wb_dat_i)) == 32'h0) else $error("pu off");
   pu_en_a:
      assert property (wr && wb_adr_i == PIO_PU_EN
         |=> (pullup_on & $past(wb_dat_i)) == $past(wb_dat_i))
      else $error("pu on");
   pu_status_a:
      assert property (rd && wb_adr_i == PIO_PU_ST
         |-> wb_dat_o == ~pullup_on) else $error("pu status");
   hole_zero_a:
      assert property (rd && wb_adr_i == 8'h0C |-> wb_dat_o == 32'h0)
      else $error("hole read");
   cover property (wr && wb_adr_i == PIO_OUT_ST);
   cover property (rd && wb_adr_i == PIO_PIN_ST);
   cover property (!periph_clk_en [*3]);
endmodule
bind pio_line_ctrl pio_line_ctrl_checker i_pio_line_ctrl_checker
(
   .clock, .resetn, .periph_clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in,
   .pullup_on, .periph_pin_in, .ctrl_irq
);

// File: tb/pio_pins_model.sv
/*
 pio_pins_model: wire level of the 32 pins.
 assumes external low drivers from the bench.
*/
`timescale 1ns/100ps
module pio_pins_model
(
   input wire logic clock,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   input wire logic [31:0] pullup_on,
   input wire logic [31:0] ext_low,
   output logic [31:0] pin_lvl
);
   logic [31:0] flip = 32'h0;
   always_ff @(posedge clock)
      flip <= ~flip;
   // driven, then external low, then pull-up, else noise
   always_comb
      for (int n = 0; n < 32; n++)
         pin_lvl[n] = !pin_oe_n[n] ? pin_out[n] : ext_low[n] ? 1'b0 :
            pullup_on[n] ? 1'b1 : flip[n];
endmodule

// File: tb/pio_line_ctrl_test.sv
/*
 pio_line_ctrl_test: register, pin drive and pin sampling tests.
 assumes pio_pins_model on the pins and the bound checker.
*/
`timescale 1ns/100ps
module pio_line_ctrl_test
   import pio_pkg::*;
;
   localparam logic [31:0] MUX = 32'h0000_FFFF;
   localparam logic [31:0] FRST = 32'hFFFF_FFFE;
   localparam logic [7:0] SA [7] = '{PIO_PU_DIS, PIO_CTRL_EN, PIO_B_SEL,
      PIO_OE_EN, PIO_OUT_SET, PIO_OW_EN, PIO_MD_EN};
   localparam logic [7:0] CA [7] = '{PIO_PU_EN, PIO_CTRL_DIS, PIO_A_SEL,
      PIO_OE_DIS, PIO_OUT_CLR, PIO_OW_DIS, PIO_MD_DIS};
   localparam logic [7:0] RA [7] = '{PIO_PU_ST, PIO_FSEL_ST, PIO_AB_ST,
      PIO_OE_ST, PIO_OUT_ST, PIO_OW_ST, PIO_MD_ST};
   logic clock = 1'b0, resetn = 1'b0, periph_clk_en = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pin_in, pin_out, pin_oe_n;
   logic [31:0] pullup_on, periph_pin_in, ext_low = 32'h0, lv;
   logic [31:0] periph_a_out = 32'h0000_000A, periph_a_oe = 32'h0000_0003;
   logic [31:0] periph_b_out = 32'h0000_0005, periph_b_oe = 32'h0000_000C;
   logic ctrl_irq;
   logic [31:0] sh [7];
   int err_total = 0, checks = 0, ticks = 0;
   pio_line_ctrl #(.MUXED(MUX), .FSEL_RESET(FRST)) i_pio_line_ctrl
   (
      .clock, .resetn, .periph_clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in,
      .pin_out, .pin_oe_n, .pullup_on, .periph_a_out, .periph_a_oe,
      .periph_b_out, .periph_b_oe, .periph_pin_in, .ctrl_irq
   );
   pio_pins_model i_pio_pins_model
   (
      .clock, .pin_out, .pin_oe_n, .pullup_on, .ext_low, .pin_lvl(pin_in)
   );
   // ----
   // tasks
   // ----
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic void upd(input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m);
      for (int i = 0; i < 7; i++)
      begin
         if (a == SA[i])
            sh[i] |= d;
         if (a == CA[i])
            sh[i] &= ~d;
      end
      if (a == PIO_OUT_ST)
         sh[4] = (sh[4] & ~(sh[5] & m)) | (d & sh[5]);
      sh[1] |= ~MUX;
   endfunction
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
         @(posedge clock);
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (w)
         upd(a, d & m, m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
      logic [31:0] q;
      bus(1'b1, a, d, s, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      check($sformatf("reg_%h", a), q, e);
   endtask
   task automatic pins(output logic [31:0] l);
      logic [31:0] v, e;
      @(posedge clock);
      #1;
      for (int n = 0; n < 32; n++)
      begin
         v[n] = sh[1][n] ? sh[4][n] : sh[2][n] ? periph_b_out[n] :
            periph_a_out[n];
         e[n] = ~(sh[1][n] ? sh[3][n] : sh[2][n] ? periph_b_oe[n] :
            periph_a_oe[n]);
         if (sh[6][n] && v[n])
            e[n] = 1'b1;
      end
      l = (~e & v) | (e & ~ext_low);
      check("pin_oe_n", pin_oe_n, e);
      check("pin_out", pin_out & ~e, v & ~e);
      check("pullup_on", pullup_on, ~sh[0]);
      @(posedge clock);
   endtask
   // ----
   // sequence
   // ----
   initial
      forever #12.5 clock = ~clock;
   always @(posedge clock)
   begin
      ticks <= ticks + 1;
      if (ticks == 3000)
      begin
         err_total++;
         end_of_test();
      end
   end
   initial
   begin
      sh = '{32'h0, FRST | ~MUX, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 7; i++)
         rc(RA[i], sh[i]);
      rc(8'h0C, 32'h0);
      rc(PIO_PIN_ST, 32'h0);
      pins(lv);
      for (int i = 0; i < 7; i++)
      begin
         wr(SA[i], 32'h00FF_00FF);
         wr(CA[i], 32'h000F_000F);
         rc(RA[i], sh[i]);
      end
      wr(PIO_OUT_ST, 32'h5A5A_5A5A);
      rc(PIO_OUT_ST, sh[4]);
      wr(PIO_OUT_SET, 32'hFFFF_FFFF, 4'h2);
      rc(PIO_OUT_ST, sh[4]);
      pins(lv);
      wr(PIO_B_SEL, 32'h0000_0003);
      pins(lv);
      wr(PIO_OE_EN, 32'h0000_000F);
      wr(PIO_OUT_SET, 32'h0000_0009);
      pins(lv);
      wr(PIO_CTRL_EN, 32'h0000_000F);
      pins(lv);
      wr(PIO_CTRL_DIS, 32'hFFFF_0000);
      rc(PIO_FSEL_ST, sh[1]);
      wr(PIO_MD_EN, 32'h0000_0001);
      pins(lv);
      wr(PIO_PU_EN, 32'hFFFF_FFFF);
      ext_low <= 32'h0F00_0000;
      pins(lv);
      periph_clk_en <= 1'b1;
      repeat (4) @(posedge clock);
      rc(PIO_PIN_ST, lv);
      check("periph_pin_in", periph_pin_in, lv);
      periph_clk_en <= 1'b0;
      repeat (4) @(posedge clock);
      ext_low <= 32'h0000_F000;
      repeat (4) @(posedge clock);
      rc(PIO_PIN_ST, lv);
      check("periph_pin_in", periph_pin_in, lv);
      end_of_test();
   end
endmodule
